// [dv/mdio_master.sv]
// management frame master standing in for the mac side
`timescale 1ns/100ps
module mdio_master
(
	input wire logic clock_i, // core clock
	input wire logic line_i, // resolved mdio wire
	output logic mdc_o, // management clock, still between frames
	output logic drv_o, // data driven by the master
	output logic oe_o // high while the master drives
);
	initial
	begin
		mdc_o = 1'b0;
		drv_o = 1'b1;
		oe_o = 1'b0;
	end

	// ten core cycles a half period keeps mdc well below the sync limit
	task automatic half();
		repeat (10) @(posedge clock_i);
	endtask

	// every frame carries its full preamble; reads sample the 16 data bits, one at each rise
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hffff_ffff, 2'b01, op, pa, ra, 2'b10, wd};
		rd = 16'h0000;
		// one idle edge so the last frame's release never meets this start
		@(posedge clock_i);
		for (int i = 63; i >= 0; i--)
		begin
			oe_o <= (op == 2'h1) || (i > 17);
			drv_o <= bits[i];
			half();
			mdc_o <= 1'b1;
			if (i < 16)
				rd[i] = line_i;
			half();
			mdc_o <= 1'b0;
		end
		oe_o <= 1'b0;
	endtask
endmodule // mdio_master

// [dv/phy_basic_control_regs_monitor.sv]
// assertions on the ports of the basic control register bank
`timescale 1ns/100ps
module phy_basic_control_regs_monitor
	import phy_ctrl_pkg::*;
#(
	parameter int unsigned RESET_HOLD_CYCLES = 16
)
(
	input wire logic clock_i, // core clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic mdc_i, // management clock pin
	input wire logic mdio_i, // management data in
	input wire logic mdio_o, // management data out
	input wire logic mdio_oe_o, // phy drives mdio
	input wire strap_t strap_i, // strap pins
	input wire logic an_speed_100_i, // negotiated speed
	input wire logic an_full_duplex_i, // negotiated duplex
	input wire mode_t mode_o, // operating mode
	input wire logic soft_reset_o, // software reset running
	input wire logic an_restart_o // autoneg restart pulse
);
	logic [7:0] hold_q;

	default clocking cb @(posedge clock_i);
	endclocking

	// counts the cycles of the current reset hold
	always_ff @(posedge clock_i)
	begin
		hold_q <= soft_reset_o ? hold_q + 8'h01 : 8'h00;
	end

	a_restart_one_cycle: assert property (disable iff (!rst_n_i) an_restart_o |=> !an_restart_o)
		else $error("restart pulse longer than one cycle");
	a_restart_not_reset: assert property (disable iff (!rst_n_i) an_restart_o |-> !soft_reset_o)
		else $error("restart pulse during software reset");
	a_hold_bounded: assert property (disable iff (!rst_n_i) soft_reset_o |-> hold_q < RESET_HOLD_CYCLES)
		else $error("software reset held too long");
	a_hold_length: assert property (disable iff (!rst_n_i) $fell(soft_reset_o) |-> hold_q == RESET_HOLD_CYCLES)
		else $error("software reset hold length wrong");
	a_soft_reload: assert property (disable iff (!rst_n_i) $fell(soft_reset_o) |=>
		!mode_o.power_down && !mode_o.loopback && !mode_o.col_test && mode_o.isolate == strap_i.isolate)
		else $error("fields not reloaded after software reset");
	a_strap_capture: assert property (disable iff (!rst_n_i) $rose(rst_n_i) |-> ##2
		mode_o.isolate == strap_i.isolate && mode_o.autoneg_en == strap_i.autoneg && !mode_o.power_down)
		else $error("strap values not captured at reset");
	a_manual_straps: assert property (disable iff (!rst_n_i) $rose(rst_n_i) ##2 !mode_o.autoneg_en |->
		mode_o.full_duplex != strap_i.duplex && mode_o.speed_100 == strap_i.speed)
		else $error("speed or duplex default wrong");
	a_autoneg_wins: assert property (disable iff (!rst_n_i) mode_o.autoneg_en && $stable(an_speed_100_i) &&
		$stable(an_full_duplex_i) |-> mode_o.speed_100 == an_speed_100_i && mode_o.full_duplex == an_full_duplex_i)
		else $error("negotiated result not used");
	a_pd_exit_quiet: assert property (disable iff (!rst_n_i) $fell(mode_o.power_down) |-> !soft_reset_o[*3])
		else $error("power-down exit started a reset");
	a_reset_quiet: assert property (!rst_n_i |=> !mdio_oe_o && !soft_reset_o && !an_restart_o && mode_o == '0)
		else $error("outputs active during reset");
endmodule // phy_basic_control_regs_monitor

bind phy_basic_control_regs phy_basic_control_regs_monitor #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) u_monitor (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o),
	.mdio_oe_o(mdio_oe_o), .strap_i(strap_i), .an_speed_100_i(an_speed_100_i),
	.an_full_duplex_i(an_full_duplex_i), .mode_o(mode_o), .soft_reset_o(soft_reset_o),
	.an_restart_o(an_restart_o));

// [dv/phy_basic_control_regs_tb.sv]
// self-checking bench for the basic control register bank
`timescale 1ns/100ps
module phy_basic_control_regs_tb;
	import phy_ctrl_pkg::*;
	localparam int unsigned HOLD = 2;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic mdc, drv, m_oe, dut_out, dut_oe, soft_reset, an_restart;
	strap_t strap = 4'ha;
	logic an_speed = 1'b1;
	logic an_duplex = 1'b0;
	mode_t mode;
	logic [15:0] restart_seen = 16'h0000;
	logic [15:0] reset_seen = 16'h0000;
	int error_cnt = 0;
	int cmp_count = 0;
	// released wire floats high through the pull-up
	wire logic line = dut_oe ? dut_out : (m_oe ? drv : 1'b1);

	always #12.5 clock = ~clock;

	always @(posedge clock)
	begin
		restart_seen <= restart_seen + {15'h0000, an_restart};
		reset_seen <= reset_seen + {15'h0000, soft_reset};
	end

	phy_basic_control_regs #(.PHY_ADDR(5'h01), .RESET_HOLD_CYCLES(HOLD)) DUT (
		.clock_i(clock), .rst_n_i(rst_n), .mdc_i(mdc), .mdio_i(line), .mdio_o(dut_out),
		.mdio_oe_o(dut_oe), .strap_i(strap), .an_speed_100_i(an_speed),
		.an_full_duplex_i(an_duplex), .mode_o(mode), .soft_reset_o(soft_reset),
		.an_restart_o(an_restart));
	mdio_master partner (.clock_i(clock), .line_i(line), .mdc_o(mdc), .drv_o(drv), .oe_o(m_oe));

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
		logic [15:0] unused;
		partner.frame(OP_WRITE, 5'h01, ra, wd, unused);
	endtask

	task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
		logic [15:0] got;
		partner.frame(OP_READ, 5'h01, ra, 16'h0000, got);
		check("read data", exp, got);
	endtask

	task automatic t_defaults();
		rd(BASIC_CONTROL_ADDR, 16'h2500);
		check("mode", 16'h0062, {9'h000, mode});
	endtask

	task automatic t_fields();
		wr(BASIC_CONTROL_ADDR, 16'h41ff);
		rd(BASIC_CONTROL_ADDR, 16'h4180);
		check("mode", 16'h0029, {9'h000, mode});
		wr(BASIC_CONTROL_ADDR, 16'h2000);
		check("mode", 16'h0040, {9'h000, mode});
	endtask

	task automatic t_autoneg();
		logic [15:0] n;
		an_speed <= 1'b0;
		an_duplex <= 1'b1;
		wr(BASIC_CONTROL_ADDR, 16'h3000);
		check("mode", 16'h0030, {9'h000, mode});
		n = restart_seen;
		wr(BASIC_CONTROL_ADDR, 16'h3200);
		check("restarts", n + 16'h0001, restart_seen);
		rd(BASIC_CONTROL_ADDR, 16'h3000);
		wr(BASIC_CONTROL_ADDR, 16'h1000);
		check("restarts", n + 16'h0001, restart_seen);
	endtask

	// foreign address and unknown opcode must leave the register alone
	task automatic t_refused();
		logic [15:0] got;
		partner.frame(OP_WRITE, 5'h02, BASIC_CONTROL_ADDR, 16'h4000, got);
		partner.frame(2'h3, 5'h01, BASIC_CONTROL_ADDR, 16'h4000, got);
		rd(BASIC_CONTROL_ADDR, 16'h1000);
	endtask

	task automatic t_unmapped();
		rd(RESERVED_9_ADDR, UNMAPPED_READ_VALUE);
		wr(AUTONEG_ADVERTISE_ADDR, 16'hffff);
		rd(AUTONEG_ADVERTISE_ADDR, UNMAPPED_READ_VALUE);
	endtask

	task automatic t_powerdown();
		logic [15:0] n;
		strap <= 4'h4;
		wr(BASIC_CONTROL_ADDR, 16'h0800);
		check("mode", 16'h0004, {9'h000, mode});
		n = reset_seen;
		wr(BASIC_CONTROL_ADDR, 16'h8000);
		rd(BASIC_CONTROL_ADDR, 16'h0000);
		check("reset cycles", n, reset_seen);
		wr(BASIC_CONTROL_ADDR, 16'h8000);
		check("reset cycles", n + 16'(HOLD), reset_seen);
		rd(BASIC_CONTROL_ADDR, 16'h1100);
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_defaults();
		t_fields();
		t_autoneg();
		t_refused();
		t_unmapped();
		t_powerdown();
		final_report();
	end

	initial
	begin
		repeat (60000) @(posedge clock);
		error_cnt++;
		$display("Error watchdog expected done seen running");
		final_report();
	end
endmodule // phy_basic_control_regs_tb

// [logic/phy_basic_control_regs.sv]
// management slave and basic control register of a 10/100 phy
// Functional notes
// - writing one to bit 15 starts a software reset; bit self-clears, reads zero after
// - speed bit picks 100 Mbps or 10 Mbps; ignored while autoneg enabled
// - with autoneg enabled, negotiated speed and duplex override the manual bits
// - bit 11 set powers down, cleared returns normal; resets to zero
// - in power-down first reset write only clears it; second fully resets, resamples straps
// - isolate bit disconnects the phy from its mac-side interface
// - writing one to bit 9 restarts autoneg; self-clears; zero does nothing
// - duplex bit picks full or half; resets to inverse of duplex strap
// - speed bit resets to the sampled speed strap level
// - autoneg enable resets to the sampled autoneg strap
// - isolate bit resets to the sampled isolate strap
`timescale 1ns/100ps
module phy_basic_control_regs
	import phy_ctrl_pkg::*;
#(
	parameter logic [PHY_ADDR_W-1:0] PHY_ADDR = 5'h01,
	parameter int unsigned RESET_HOLD_CYCLES = 16
)
(
	input wire logic clock_i, // 40 MHz core clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic mdc_i, // management clock pin
	input wire logic mdio_i, // management data pin, input side
	output logic mdio_o, // management data pin, output side
	output logic mdio_oe_o, // high while the phy drives mdio
	input wire strap_t strap_i, // strap pins
	input wire logic an_speed_100_i, // negotiated speed result
	input wire logic an_full_duplex_i, // negotiated duplex result
	output mode_t mode_o, // operating mode to the phy core
	output logic soft_reset_o, // high while software reset runs
	output logic an_restart_o // one-cycle autoneg restart request
);

	localparam int unsigned HOLD_W = $clog2(RESET_HOLD_CYCLES + 1);
	localparam int unsigned STRAP_W = $bits(strap_t);
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD_CYCLES - 1);

	logic [1:0] pin_sync;
	logic [STRAP_W-1:0] strap_bits;
	strap_t strap_sync;
	logic mdc_sync;
	logic mdio_sync;
	logic mdc_prev_q;
	logic mdc_rise;

	mdio_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [DATA_W-1:0] sh_q;
	logic [DATA_W-1:0] shift_in;
	logic is_read_q;
	logic hit_q;
	logic [REG_ADDR_W-1:0] reg_q;
	logic out_q;
	logic oe_q;
	logic wr_q;
	logic [DATA_W-1:0] wdata_q;

	logic loopback_q;
	logic speed_q;
	logic an_en_q;
	logic power_down_q;
	logic isolate_q;
	logic duplex_q;
	logic col_test_q;
	logic resetting_q;
	logic [HOLD_W-1:0] hold_cnt_q;
	logic an_restart_q;
	logic ctrl_write;
	logic [DATA_W-1:0] ctrl_word;
	logic [DATA_W-1:0] read_word;
	mode_t mode_q;

	sync_2ff #(
		.WIDTH(2)
	) u_pin_sync (
		.clock_i(clock_i),
		.d_i({mdc_i, mdio_i}),
		.q_o(pin_sync)
	);

	sync_2ff #(
		.WIDTH(STRAP_W)
	) u_strap_sync (
		.clock_i(clock_i),
		.d_i(strap_i),
		.q_o(strap_bits)
	);

	assign mdc_sync = pin_sync[1];
	assign mdio_sync = pin_sync[0];
	assign strap_sync = strap_t'(strap_bits);
	assign mdc_rise = mdc_sync & ~mdc_prev_q;
	assign shift_in = {sh_q[DATA_W-2:0], mdio_sync};

	// frame decoding; the phy changes mdio just after the edge the master samples on
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			mdc_prev_q <= 1'b0;
			state_q <= S_PRE;
			cnt_q <= '0;
			sh_q <= '0;
			is_read_q <= 1'b0;
			hit_q <= 1'b0;
			reg_q <= '0;
			out_q <= 1'b0;
			oe_q <= 1'b0;
			wr_q <= 1'b0;
			wdata_q <= '0;
		end
		else
		begin
			mdc_prev_q <= mdc_sync;
			wr_q <= 1'b0;
			if (mdc_rise)
			begin
				// every field counts up; the branches below restart it
				cnt_q <= cnt_q + 6'h01;
				case (state_q)
					S_PRE:
					begin
						// saturate so a long idle run still counts as a preamble
						if (mdio_sync && (cnt_q == PREAMBLE_BITS))
						begin
							cnt_q <= cnt_q;
						end
						else if (!mdio_sync)
						begin
							cnt_q <= '0;
							state_q <= (cnt_q == PREAMBLE_BITS) ? S_ST : S_PRE;
						end
					end
					S_ST:
					begin
						cnt_q <= '0;
						state_q <= mdio_sync ? S_OP : S_PRE;
					end
					S_OP:
					begin
						sh_q <= shift_in;
						if (cnt_q == OP_LAST)
						begin
							cnt_q <= '0;
							is_read_q <= (shift_in[1:0] == OP_READ);
							if ((shift_in[1:0] == OP_READ) || (shift_in[1:0] == OP_WRITE))
							begin
								state_q <= S_ADDR;
							end
							else
							begin
								// unknown opcode: wait for a fresh preamble
								state_q <= S_PRE;
							end
						end
					end
					S_ADDR:
					begin
						sh_q <= shift_in;
						if (cnt_q == ADDR_LAST)
						begin
							cnt_q <= '0;
							hit_q <= (shift_in[9:5] == PHY_ADDR);
							reg_q <= shift_in[REG_ADDR_W-1:0];
							state_q <= S_TA;
						end
					end
					S_TA:
					begin
						if (cnt_q == TA_LAST)
						begin
							cnt_q <= '0;
							state_q <= S_DATA;
							if (is_read_q && hit_q)
							begin
								out_q <= read_word[DATA_W-1];
								sh_q <= {read_word[DATA_W-2:0], 1'b0};
							end
						end
						// second turnaround bit driven low by the phy
						else if (is_read_q && hit_q)
						begin
							oe_q <= 1'b1;
							out_q <= 1'b0;
						end
					end
					S_DATA:
					begin
						// held low on writes and misses so the unused output stays quiet
						out_q <= is_read_q & hit_q & sh_q[DATA_W-1];
						sh_q <= is_read_q ? {sh_q[DATA_W-2:0], 1'b0} : shift_in;
						if (cnt_q == DATA_LAST)
						begin
							cnt_q <= '0;
							oe_q <= 1'b0;
							out_q <= 1'b0;
							state_q <= S_PRE;
							wr_q <= ~is_read_q & hit_q;
							wdata_q <= shift_in;
						end
					end
					default:
					begin
						state_q <= S_PRE;
						cnt_q <= '0;
						oe_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// writes landing during the reset hold are dropped
	assign ctrl_write = wr_q & (reg_q == BASIC_CONTROL_ADDR) & ~resetting_q;

	// control fields; straps are caught while the chip reset is held
	always_ff @(posedge clock_i)
	begin
		// straps resampled at the end of a software reset
		if (!rst_n_i || (resetting_q && (hold_cnt_q == HOLD_LAST)))
		begin
			speed_q <= strap_sync.speed;
			an_en_q <= strap_sync.autoneg;
			isolate_q <= strap_sync.isolate;
			duplex_q <= ~strap_sync.duplex;
			loopback_q <= 1'b0;
			power_down_q <= 1'b0;
			col_test_q <= 1'b0;
		end
		else if (ctrl_write)
		begin
			if (wdata_q[CTRL_RESET_BIT])
			begin
				if (power_down_q)
				begin
					power_down_q <= 1'b0;
				end
			end
			else
			begin
				loopback_q <= wdata_q[CTRL_LOOPBACK_BIT];
				speed_q <= wdata_q[CTRL_SPEED_BIT];
				an_en_q <= wdata_q[CTRL_AN_EN_BIT];
				power_down_q <= wdata_q[CTRL_POWER_DOWN_BIT];
				isolate_q <= wdata_q[CTRL_ISOLATE_BIT];
				duplex_q <= wdata_q[CTRL_DUPLEX_BIT];
				col_test_q <= wdata_q[CTRL_COL_TEST_BIT];
			end
		end
	end

	// software reset runs a fixed hold, then self-clears
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			resetting_q <= 1'b0;
			hold_cnt_q <= '0;
		end
		else if (resetting_q)
		begin
			resetting_q <= (hold_cnt_q != HOLD_LAST);
			hold_cnt_q <= (hold_cnt_q == HOLD_LAST) ? '0 : hold_cnt_q + HOLD_W'(1);
		end
		else if (ctrl_write && wdata_q[CTRL_RESET_BIT] && !power_down_q)
		begin
			resetting_q <= 1'b1;
			hold_cnt_q <= '0;
		end
	end

	// restart is ignored when the same write also asks for reset
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			an_restart_q <= 1'b0;
		end
		else
		begin
			an_restart_q <= ctrl_write & wdata_q[CTRL_AN_RESTART_BIT] &
				~wdata_q[CTRL_RESET_BIT];
		end
	end

	always_comb
	begin
		ctrl_word = '0;
		ctrl_word[CTRL_RESET_BIT] = resetting_q;
		ctrl_word[CTRL_LOOPBACK_BIT] = loopback_q;
		ctrl_word[CTRL_SPEED_BIT] = speed_q;
		ctrl_word[CTRL_AN_EN_BIT] = an_en_q;
		ctrl_word[CTRL_POWER_DOWN_BIT] = power_down_q;
		ctrl_word[CTRL_ISOLATE_BIT] = isolate_q;
		ctrl_word[CTRL_AN_RESTART_BIT] = 1'b0;
		ctrl_word[CTRL_DUPLEX_BIT] = duplex_q;
		ctrl_word[CTRL_COL_TEST_BIT] = col_test_q;
	end

	// other register numbers belong to blocks outside this one
	assign read_word = (reg_q == BASIC_CONTROL_ADDR) ? ctrl_word : UNMAPPED_READ_VALUE;

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			mode_q <= '0;
		end
		else
		begin
			mode_q.speed_100 <= an_en_q ? an_speed_100_i : speed_q;
			mode_q.full_duplex <= an_en_q ? an_full_duplex_i : duplex_q;
			mode_q.autoneg_en <= an_en_q;
			mode_q.loopback <= loopback_q;
			mode_q.power_down <= power_down_q;
			mode_q.isolate <= isolate_q;
			mode_q.col_test <= col_test_q;
		end
	end

	assign mode_o = mode_q;
	assign soft_reset_o = resetting_q;
	assign an_restart_o = an_restart_q;
	assign mdio_o = out_q;
	assign mdio_oe_o = oe_q;

endmodule // phy_basic_control_regs

// [logic/phy_ctrl_pkg.sv]
// shared constants and types for the phy management register bank
package phy_ctrl_pkg;

	localparam int unsigned PHY_ADDR_W = 5;
	localparam int unsigned REG_ADDR_W = 5;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned CNT_W = 6;

	// register numbers on the management interface
	localparam logic [REG_ADDR_W-1:0] BASIC_CONTROL_ADDR = 5'h00;
	localparam logic [REG_ADDR_W-1:0] BASIC_STATUS_ADDR = 5'h01;
	localparam logic [REG_ADDR_W-1:0] PHY_IDENT_HIGH_ADDR = 5'h02;
	localparam logic [REG_ADDR_W-1:0] PHY_IDENT_LOW_ADDR = 5'h03;
	localparam logic [REG_ADDR_W-1:0] AUTONEG_ADVERTISE_ADDR = 5'h04;
	localparam logic [REG_ADDR_W-1:0] LINK_PARTNER_ABILITY_ADDR = 5'h05;
	localparam logic [REG_ADDR_W-1:0] AUTONEG_EXPANSION_ADDR = 5'h06;
	localparam logic [REG_ADDR_W-1:0] AUTONEG_NEXT_PAGE_ADDR = 5'h07;
	localparam logic [REG_ADDR_W-1:0] PARTNER_NEXT_PAGE_ADDR = 5'h08;
	localparam logic [REG_ADDR_W-1:0] RESERVED_9_ADDR = 5'h09;
	localparam logic [REG_ADDR_W-1:0] DIGITAL_MISC_CONTROL_ADDR = 5'h10;
	localparam logic [REG_ADDR_W-1:0] ANALOG_FRONTEND_CONTROL_ADDR = 5'h11;
	localparam logic [REG_ADDR_W-1:0] RECEIVE_ERROR_COUNTER_ADDR = 5'h15;
	localparam logic [REG_ADDR_W-1:0] STRAP_OVERRIDE_ADDR = 5'h16;
	localparam logic [REG_ADDR_W-1:0] STRAP_STATUS_ADDR = 5'h17;
	localparam logic [REG_ADDR_W-1:0] EXPANDED_CONTROL_ADDR = 5'h18;
	localparam logic [REG_ADDR_W-1:0] IRQ_CONTROL_STATUS_ADDR = 5'h1b;
	localparam logic [REG_ADDR_W-1:0] RESERVED_1C_ADDR = 5'h1c;
	localparam logic [REG_ADDR_W-1:0] CABLE_DIAG_CONTROL_ADDR = 5'h1d;
	localparam logic [REG_ADDR_W-1:0] PHY_CONTROL_ONE_ADDR = 5'h1e;
	localparam logic [REG_ADDR_W-1:0] PHY_CONTROL_TWO_ADDR = 5'h1f;

	// basic_control field positions
	localparam int unsigned CTRL_RESET_BIT = 15;
	localparam int unsigned CTRL_LOOPBACK_BIT = 14;
	localparam int unsigned CTRL_SPEED_BIT = 13;
	localparam int unsigned CTRL_AN_EN_BIT = 12;
	localparam int unsigned CTRL_POWER_DOWN_BIT = 11;
	localparam int unsigned CTRL_ISOLATE_BIT = 10;
	localparam int unsigned CTRL_AN_RESTART_BIT = 9;
	localparam int unsigned CTRL_DUPLEX_BIT = 8;
	localparam int unsigned CTRL_COL_TEST_BIT = 7;
	localparam logic [DATA_W-1:0] UNMAPPED_READ_VALUE = 16'h0000;

	// management frame fields
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [CNT_W-1:0] PREAMBLE_BITS = 6'h20;
	localparam logic [CNT_W-1:0] OP_LAST = 6'h01;
	localparam logic [CNT_W-1:0] ADDR_LAST = 6'h09;
	localparam logic [CNT_W-1:0] TA_LAST = 6'h01;
	localparam logic [CNT_W-1:0] DATA_LAST = 6'h0f;

	typedef struct packed {
		logic speed;
		logic autoneg;
		logic isolate;
		logic duplex;
	} strap_t;

	typedef struct packed {
		logic speed_100;
		logic full_duplex;
		logic autoneg_en;
		logic loopback;
		logic power_down;
		logic isolate;
		logic col_test;
	} mode_t;

	typedef enum logic [2:0] {
		S_PRE = 3'h0,
		S_ST = 3'h1,
		S_OP = 3'h3,
		S_ADDR = 3'h2,
		S_TA = 3'h6,
		S_DATA = 3'h7
	} mdio_state_t;

endpackage

// [logic/sync_2ff.sv]
// two flip-flop synchroniser for pins entering the core clock domain
`timescale 1ns/100ps
module sync_2ff
#(
	parameter int unsigned WIDTH = 1
)
(
	input wire logic clock_i, // core clock
	input wire logic [WIDTH-1:0] d_i, // asynchronous level
	output logic [WIDTH-1:0] q_o // synchronised level
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// no reset so straps settle while the chip reset is held
	always_ff @(posedge clock_i)
	begin
		meta_q <= d_i;
		sync_q <= meta_q;
	end

	assign q_o = sync_q;

endmodule // sync_2ff
